// *** verilog/pas_pkg.sv ***
// Purpose: shared constants, types and helpers of the power accumulator sequencer
// Assumes: 10 MHz core clock, four measured channels plus one offset channel
// Notes: all arithmetic is two's complement
package pas_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int NUM_CH = 4;
  localparam int SAMP_W = 17;
  localparam int RES_W = 16;
  localparam int BUS_MSB_W = 14;
  localparam int POW_W = 30;
  localparam int ACC_W = 56;
  localparam int CNT_W = 32;
  localparam int AVG_SHIFT = 3;
  localparam int SUM_W = SAMP_W + AVG_SHIFT;
  localparam int HIST_DEPTH = 32;
  localparam int SLOW_SHIFT = 7;
  localparam int PERIOD_W = 21;
  localparam int PULSE_W = 6;

  // ****************************************
  // values and steps
  // ****************************************
  localparam logic [CNT_W-1:0] CNT_STEP = 32'h0000_0001;
  localparam logic [CNT_W-1:0] CNT_STEP_SLOW = 32'h0000_0080;
  localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFF_FFFF;
  localparam logic [ACC_W-1:0] ACC_MAX = 56'h7F_FFFF_FFFF_FFFF;
  localparam logic [ACC_W-1:0] ACC_MIN = 56'h80_0000_0000_0000;
  localparam logic [2:0] OFFSET_CH = 3'h4;
  localparam logic [2:0] NO_CH = 3'h7;
  localparam logic [3:0] SHOTS_8X = 4'h8;
  localparam logic [3:0] SHOTS_1 = 4'h1;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int FAST_SPS = 1024;
  localparam int SLOW_SPS = 8;
  localparam int ALERT_PULSE_NS = 5000;
  localparam int ALERT_PULSE_CYC = (ALERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    MODE_CONT = 3'b000,
    MODE_BURST = 3'b001,
    MODE_FAST = 3'b010,
    MODE_SINGLE = 3'b011,
    MODE_SINGLE8 = 3'b100
  } pas_mode_t;

  typedef enum logic [1:0] {
    SEL_POWER = 2'b00,
    SEL_SENSE = 2'b01,
    SEL_BUS = 2'b10,
    SEL_POWER_ALT = 2'b11
  } pas_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_WAIT = 3'b010,
    ST_CALC = 3'b011,
    ST_ACCUM = 3'b100,
    ST_END = 3'b101,
    ST_SLEEP = 3'b110
  } pas_state_t;

  // ****************************************
  // helpers
  // ****************************************
  // readable 16-bit form of a 17-bit sample
  function automatic logic [RES_W-1:0] fmt16(input logic [SAMP_W-1:0] s, input logic bipolar,
                                             input logic half);
    logic [SAMP_W-1:0] v;
    v = half ? (s << 1) : s;
    fmt16 = bipolar ? v[SAMP_W-1:1] : v[RES_W-1:0];
  endfunction : fmt16

  // fullness threshold of a counter whose top value is given
  function automatic logic [63:0] fill_thr(input logic [63:0] top, input logic [1:0] lvl);
    unique case (lvl)
      2'b00: fill_thr = top - (top >> 4);
      2'b01: fill_thr = top - (top >> 3);
      2'b10: fill_thr = top - (top >> 2);
      2'b11: fill_thr = top;
    endcase
  endfunction : fill_thr

  // first enabled channel at or after from, else offset or none
  function automatic logic [2:0] next_chan(input logic [NUM_CH-1:0] en, input logic [2:0] from,
                                           input logic with_off);
    logic [2:0] r;
    r = with_off ? OFFSET_CH : NO_CH;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (en[i] && (3'(i) >= from))
        r = 3'(i);
    end
    return r;
  endfunction : next_chan

endpackage : pas_pkg

// *** verilog/pas_hist_mem.sv ***
// Purpose: small sample history memory with registered read
// Assumes: one write and one read port on one clock
// Notes: contents undefined until written
`timescale 1ns/1ps
module pas_hist_mem #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  if (DEPTH < 2 || WIDTH < 1)
  begin : g_bad_param
    $error("pas_hist_mem: bad size");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule : pas_hist_mem

// *** verilog/pas_sample_math.sv ***
// Purpose: power product and accumulator addend of one sample
// Assumes: samples already offset corrected
// Notes: purely combinational
`timescale 1ns/1ps
module pas_sample_math
  import pas_pkg::*;
(
  input wire logic [SAMP_W-1:0] bus,
  input wire logic [SAMP_W-1:0] sense,
  input wire pas_sel_t sel,
  input wire logic slow_adapt,
  output logic [POW_W-1:0] power,
  output logic [ACC_W-1:0] addend
);

  logic signed [SAMP_W+BUS_MSB_W-1:0] prod;
  logic [ACC_W-1:0] base;

  // full sense times top bits of bus
  assign prod = $signed(sense) * $signed(bus[SAMP_W-1:SAMP_W-BUS_MSB_W]);
  assign power = prod[POW_W-1:0];

  always_comb
  begin
    unique case (sel)
      SEL_SENSE: base = {{(ACC_W-SAMP_W){sense[SAMP_W-1]}}, sense};
      SEL_BUS: base = {{(ACC_W-SAMP_W){bus[SAMP_W-1]}}, bus};
      SEL_POWER, SEL_POWER_ALT: base = {{(ACC_W-POW_W){power[POW_W-1]}}, power};
    endcase
    addend = slow_adapt ? (base << SLOW_SHIFT) : base;
  end

endmodule : pas_sample_math

// *** verilog/pas_sequencer.sv ***
// Purpose: round-robin sequencer, power math, accumulators and result copies
// Assumes: converter and refresh strobes run on clk; slow_pin is asynchronous
// Notes: channel 4 of the converter is the offset calibration input
`timescale 1ns/1ps

module pas_sequencer
  import pas_pkg::*;
#(
  parameter int RR_PERIOD_CYC = CLK_HZ / FAST_SPS,
  parameter int SLOW_PERIOD_CYC = CLK_HZ / SLOW_SPS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [NUM_CH-1:0] chan_enable,
  input wire pas_mode_t conv_mode,
  input wire logic bus_bipolar,
  input wire logic sense_bipolar,
  input wire logic half_range_setting,
  input wire logic [2*NUM_CH-1:0] acc_select,
  input wire logic [1:0] full_level,
  input wire logic adaptive_en,
  input wire logic slow_pin,
  input wire logic cc_alert_en,
  input wire logic refresh,
  input wire logic refresh_v,
  input wire logic refresh_g,
  input wire logic adc_done,
  input wire logic [SAMP_W-1:0] adc_bus,
  input wire logic [SAMP_W-1:0] adc_sense,
  output logic adc_start,
  output logic [2:0] adc_chan,
  output logic [NUM_CH-1:0][RES_W-1:0] bus_result,
  output logic [NUM_CH-1:0][RES_W-1:0] sense_result,
  output logic [NUM_CH-1:0][RES_W-1:0] bus_avg_result,
  output logic [NUM_CH-1:0][RES_W-1:0] sense_avg_result,
  output logic [NUM_CH-1:0][POW_W-1:0] power_result,
  output logic [NUM_CH-1:0][ACC_W-1:0] acc_result,
  output logic [NUM_CH-1:0][CNT_W-1:0] count_result,
  output logic [NUM_CH-1:0] full_event,
  output logic alert_n,
  output logic cycle_done,
  output logic asleep
);

  if (RR_PERIOD_CYC < 2 || SLOW_PERIOD_CYC < 2 || SLOW_PERIOD_CYC >= 2**PERIOD_W
      || RR_PERIOD_CYC >= 2**PERIOD_W)
  begin : g_bad_param
    $error("pas_sequencer: period out of range");
  end

  // ****************************************
  // declarations
  // ****************************************
  pas_state_t state;
  pas_state_t next_state;
  logic slow_meta, slow_s;
  logic [2:0] cur_ch, from_ch, first_ch;
  logic [1:0] ci;
  logic [3:0] shots_left;
  logic [PERIOD_W-1:0] period_cnt, period_last;
  logic period_tick, refresh_any, single, en_any, single_burst, adapt_slow;
  logic [SAMP_W-1:0] s_bus, s_sense, off_bus, off_sense, old_bus, old_sense;
  logic [NUM_CH-1:0][2:0] wr_ptr;
  logic [NUM_CH-1:0] hist_full;
  logic [NUM_CH-1:0][SUM_W-1:0] bus_sum, sense_sum;
  logic [SUM_W-1:0] next_bus_sum, next_sense_sum;
  logic [NUM_CH-1:0][SAMP_W-1:0] bus_live, sense_live, bus_avg_live, sense_avg_live;
  logic [NUM_CH-1:0][POW_W-1:0] power_live;
  logic [NUM_CH-1:0][ACC_W-1:0] acc;
  logic [NUM_CH-1:0][CNT_W-1:0] cnt;
  logic [2*SAMP_W-1:0] hist_rd;
  logic [POW_W-1:0] power;
  logic [ACC_W-1:0] addend, next_acc, acc_thr;
  logic [ACC_W:0] acc_sum;
  logic [CNT_W-1:0] cnt_inc, next_cnt, cnt_thr;
  logic hit;
  logic full_pend, alert_latch;
  logic [PULSE_W-1:0] cc_cnt;

  assign ci = cur_ch[1:0];
  assign refresh_any = refresh | refresh_v | refresh_g;
  assign single = (conv_mode == MODE_SINGLE) || (conv_mode == MODE_SINGLE8);
  assign en_any = |chan_enable;
  assign single_burst = (conv_mode == MODE_BURST) && ($countones(chan_enable) == 1);
  assign adapt_slow = adaptive_en & slow_s;
  assign first_ch = next_chan(chan_enable, from_ch, conv_mode != MODE_BURST);

  // ****************************************
  // slow pin sync and rate timer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      slow_meta <= 1'b0;
      slow_s <= 1'b0;
    end
    else
    begin
      slow_meta <= slow_pin;
      slow_s <= slow_meta;
    end
  end

  assign period_last = slow_s ? PERIOD_W'(SLOW_PERIOD_CYC - 1) : PERIOD_W'(RR_PERIOD_CYC - 1);
  assign period_tick = (period_cnt >= period_last);

  always_ff @(posedge clk)
  begin
    if (srst || period_tick)
      period_cnt <= '0;
    else
      period_cnt <= period_cnt + PERIOD_W'(1);
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (en_any && (single ? refresh_any : (conv_mode != MODE_CONT || period_tick)))
          next_state = ST_START;
      end
      ST_START:
      begin
        if (!en_any)
          next_state = ST_IDLE;
        else if (first_ch == NO_CH)
          next_state = ST_END;
        else
          next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (adc_done)
          next_state = (cur_ch == OFFSET_CH) ? ST_END : ST_CALC;
      end
      ST_CALC: next_state = ST_ACCUM;
      ST_ACCUM: next_state = ST_START;
      ST_END:
      begin
        if (single)
          next_state = (shots_left > SHOTS_1) ? ST_START : ST_IDLE;
        else if (conv_mode == MODE_CONT)
          next_state = ST_SLEEP;
        else
          next_state = ST_START;
      end
      ST_SLEEP:
      begin
        if (period_tick)
          next_state = ST_START;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cur_ch <= 3'h0;
      from_ch <= 3'h0;
      adc_start <= 1'b0;
      adc_chan <= 3'h0;
      shots_left <= 4'h0;
      cycle_done <= 1'b0;
      asleep <= 1'b1;
    end
    else
    begin
      adc_start <= (state == ST_START) && (next_state == ST_WAIT);
      cycle_done <= (state == ST_END);
      asleep <= (next_state == ST_IDLE) || (next_state == ST_SLEEP);
      if (state == ST_START && next_state == ST_WAIT)
      begin
        cur_ch <= first_ch;
        adc_chan <= first_ch;
      end
      if (state == ST_ACCUM)
        from_ch <= cur_ch + 3'h1;
      else if (state != ST_START && state != ST_WAIT && state != ST_CALC)
        from_ch <= 3'h0;
      // one refresh in single mode only; later ones are ignored until idle
      if (state == ST_IDLE && single && refresh_any)
        shots_left <= (conv_mode == MODE_SINGLE8) ? SHOTS_8X : SHOTS_1;
      else if (state == ST_END && shots_left != 4'h0)
        shots_left <= shots_left - 4'h1;
    end
  end

  // ****************************************
  // capture and offset correction
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_bus <= '0;
      s_sense <= '0;
      off_bus <= '0;
      off_sense <= '0;
    end
    else if (state == ST_WAIT && adc_done)
    begin
      if (cur_ch == OFFSET_CH)
      begin
        off_bus <= adc_bus;
        off_sense <= adc_sense;
      end
      else
      begin
        s_bus <= adc_bus - off_bus;
        s_sense <= adc_sense - off_sense;
      end
    end
  end

  // ****************************************
  // eight-sample averages
  // ****************************************
  pas_hist_mem #(
    .WIDTH(2 * SAMP_W),
    .DEPTH(HIST_DEPTH)
  ) u_hist (
    .clk(clk),
    .wr_en(state == ST_ACCUM),
    .wr_addr({ci, wr_ptr[ci]}),
    .wr_data({s_bus, s_sense}),
    .rd_addr({ci, wr_ptr[ci]}),
    .rd_data(hist_rd)
  );

  assign old_bus = hist_full[ci] ? hist_rd[2*SAMP_W-1:SAMP_W] : '0;
  assign old_sense = hist_full[ci] ? hist_rd[SAMP_W-1:0] : '0;
  assign next_bus_sum = bus_sum[ci] + {{AVG_SHIFT{s_bus[SAMP_W-1]}}, s_bus}
                        - {{AVG_SHIFT{old_bus[SAMP_W-1]}}, old_bus};
  assign next_sense_sum = sense_sum[ci] + {{AVG_SHIFT{s_sense[SAMP_W-1]}}, s_sense}
                          - {{AVG_SHIFT{old_sense[SAMP_W-1]}}, old_sense};

  // ****************************************
  // power and accumulation
  // ****************************************
  pas_sample_math u_math (
    .bus(s_bus),
    .sense(s_sense),
    .sel(pas_sel_t'(acc_select[2*ci +: 2])),
    .slow_adapt(adapt_slow),
    .power(power),
    .addend(addend)
  );

  assign acc_sum = {acc[ci][ACC_W-1], acc[ci]} + {addend[ACC_W-1], addend};
  assign cnt_inc = adapt_slow ? CNT_STEP_SLOW : CNT_STEP;
  assign next_cnt = cnt[ci] + cnt_inc;
  assign acc_thr = ACC_W'(fill_thr(64'(ACC_MAX), full_level));
  assign cnt_thr = CNT_W'(fill_thr(64'(CNT_MAX), full_level));

  always_comb
  begin
    if (acc[ci] == ACC_MAX)
      next_acc = ACC_MAX;
    else if (acc_sum[ACC_W] != acc_sum[ACC_W-1])
      next_acc = acc_sum[ACC_W] ? ACC_MIN : ACC_MAX;
    else
      next_acc = acc_sum[ACC_W-1:0];
    hit = ($signed(acc[ci]) < $signed(acc_thr) && $signed(next_acc) >= $signed(acc_thr))
          || (cnt[ci] < cnt_thr && next_cnt >= cnt_thr);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      acc <= '0;
      cnt <= '0;
      power_live <= '0;
      bus_live <= '0;
      sense_live <= '0;
      bus_avg_live <= '0;
      sense_avg_live <= '0;
      bus_sum <= '0;
      sense_sum <= '0;
      wr_ptr <= '0;
      hist_full <= '0;
      full_event <= '0;
    end
    else
    begin
      full_event <= '0;
      if (state == ST_ACCUM)
      begin
        acc[ci] <= next_acc;
        cnt[ci] <= next_cnt;
        power_live[ci] <= power;
        bus_live[ci] <= s_bus;
        sense_live[ci] <= s_sense;
        bus_sum[ci] <= next_bus_sum;
        sense_sum[ci] <= next_sense_sum;
        bus_avg_live[ci] <= next_bus_sum[SUM_W-1:AVG_SHIFT];
        sense_avg_live[ci] <= next_sense_sum[SUM_W-1:AVG_SHIFT];
        wr_ptr[ci] <= wr_ptr[ci] + 3'h1;
        if (wr_ptr[ci] == 3'h7)
          hist_full[ci] <= 1'b1;
        full_event[ci] <= hit;
      end
    end
  end

  // ****************************************
  // readable copies
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bus_result <= '0;
      sense_result <= '0;
      bus_avg_result <= '0;
      sense_avg_result <= '0;
      power_result <= '0;
      acc_result <= '0;
      count_result <= '0;
    end
    else if (refresh_any)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        bus_result[i] <= fmt16(bus_live[i], bus_bipolar, 1'b0);
        sense_result[i] <= fmt16(sense_live[i], sense_bipolar, half_range_setting);
        bus_avg_result[i] <= fmt16(bus_avg_live[i], bus_bipolar, 1'b0);
        sense_avg_result[i] <= fmt16(sense_avg_live[i], sense_bipolar, half_range_setting);
      end
      power_result <= power_live;
      acc_result <= acc;
      count_result <= cnt;
    end
  end

  // ****************************************
  // alert output
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      full_pend <= 1'b0;
      alert_latch <= 1'b0;
      cc_cnt <= '0;
      alert_n <= 1'b1;
    end
    else
    begin
      if (state == ST_ACCUM && hit)
        full_pend <= 1'b1;
      else if (state == ST_END)
        full_pend <= 1'b0;
      // set at cycle end wins over a refresh clear
      alert_latch <= (alert_latch & ~(refresh | refresh_g))
                     | ((state == ST_END) & full_pend);
      if (state == ST_END && cc_alert_en && !single_burst)
        cc_cnt <= PULSE_W'(ALERT_PULSE_CYC);
      else if (cc_cnt != '0)
        cc_cnt <= cc_cnt - PULSE_W'(1);
      alert_n <= ~(alert_latch | (cc_cnt != '0));
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_power_math;
    (state == ST_ACCUM && cur_ch != OFFSET_CH) |=> $signed(power_live[$past(ci)]) ==
      $signed($past(s_sense)) * $signed($past(s_bus[SAMP_W-1:SAMP_W-BUS_MSB_W]));
  endproperty
  a_power_math: assert property (p_power_math) else $error("power product wrong");

  property p_acc_hold;
    acc[0] == ACC_MAX |=> acc[0] == ACC_MAX;
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("accumulator left maximum");

  property p_count_step;
    (state == ST_ACCUM && cur_ch == 3'h0) |=> cnt[0] == $past(cnt[0]) + $past(cnt_inc);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  property p_burst_restart;
    (state == ST_END && conv_mode == MODE_BURST) |=> state == ST_START;
  endproperty
  a_burst_restart: assert property (p_burst_restart) else $error("burst slept");

  property p_burst_no_offset;
    (adc_start && $past(conv_mode) == MODE_BURST) |-> adc_chan != OFFSET_CH;
  endproperty
  a_burst_no_offset: assert property (p_burst_no_offset) else $error("offset in burst");

  property p_cc_pulse;
    (state == ST_END && cc_alert_en && !single_burst) |=> ##1 !alert_n;
  endproperty
  a_cc_pulse: assert property (p_cc_pulse) else $error("no completion pulse");

  property p_cc_len;
    (state == ST_END && cc_alert_en && !single_burst) |=> cc_cnt == PULSE_W'(ALERT_PULSE_CYC);
  endproperty
  a_cc_len: assert property (p_cc_len) else $error("pulse length wrong");

  property p_alert_at_end;
    $rose(alert_latch) |-> $past(state) == ST_END;
  endproperty
  a_alert_at_end: assert property (p_alert_at_end) else $error("alert mid cycle");

  property p_refresh_v_keeps;
    (alert_latch && refresh_v && !refresh && !refresh_g) |=> alert_latch;
  endproperty
  a_refresh_v_keeps: assert property (p_refresh_v_keeps) else $error("alert lost");

  property p_all_off_sleep;
    (state == ST_IDLE && !en_any) |=> state == ST_IDLE && asleep;
  endproperty
  a_all_off_sleep: assert property (p_all_off_sleep) else $error("woke with no channel");

  property p_refresh_copy;
    refresh_any |=> count_result == $past(cnt) && acc_result == $past(acc);
  endproperty
  a_refresh_copy: assert property (p_refresh_copy) else $error("copy wrong");

  c_burst_cycle: cover property (state == ST_END && conv_mode == MODE_BURST);
  c_eight_shots: cover property (state == ST_END && conv_mode == MODE_SINGLE8
                                 && shots_left == SHOTS_1);
  c_alert_latched: cover property ($rose(alert_latch));

endmodule : pas_sequencer

// *** sim/pas_adc_model.sv ***
// Purpose: converter model answering start requests with fixed samples
// Assumes: one conversion outstanding at a time
// Notes: sample lines show the inverse of the last value outside done
`timescale 1ns/1ps
module pas_adc_model
  import pas_pkg::*;
#(
  parameter int DLY = 5
) (
  input wire logic clk,
  input wire logic adc_start,
  input wire logic [2:0] adc_chan,
  output logic adc_done,
  output logic [SAMP_W-1:0] adc_bus,
  output logic [SAMP_W-1:0] adc_sense
);
  // ****************************************
  // conversion answer
  // ****************************************
  int c;
  initial
  begin
    adc_done = 1'b0;
    adc_bus = '0;
    adc_sense = '0;
    forever
    begin
      @(posedge clk);
      if (adc_start === 1'b1)
      begin
        c = int'(adc_chan);
        repeat (DLY) @(posedge clk);
        adc_done <= 1'b1;
        adc_bus <= (c == 4) ? '0 : 17'h0_8000 + 17'(c * 16);
        adc_sense <= (c == 4) ? '0 : 17'(-64 * (c + 1));
        @(posedge clk);
        adc_done <= 1'b0;
        adc_bus <= ~adc_bus;
        adc_sense <= ~adc_sense;
      end
    end
  end
endmodule : pas_adc_model

// *** sim/test_power_accumulator_sequencer.sv ***
// Purpose: self-checking bench of the sequencer in all conversion modes
// Assumes: converter model answers each start after a fixed delay
// Notes: refreshes triggering shots are spaced 2 ms apart
`timescale 1ns/1ps
module test_power_accumulator_sequencer
  import pas_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] en = 4'h0;
  pas_mode_t mode = MODE_SINGLE;
  logic bb = 1'b0;
  logic sb = 1'b0;
  logic [2:0] rf = 3'h0;
  logic [7:0] sel = 8'h24;
  logic adc_done, adc_start;
  logic [2:0] adc_chan;
  logic [SAMP_W-1:0] adc_bus, adc_sense;
  logic [NUM_CH-1:0][RES_W-1:0] bus_r, sense_r, bus_a, sense_a;
  logic [NUM_CH-1:0][POW_W-1:0] pow_r;
  logic [NUM_CH-1:0][ACC_W-1:0] acc_r;
  logic [NUM_CH-1:0][CNT_W-1:0] cnt_r;
  logic alert_n, asleep;
  int mismatches = 0;
  int total_checks = 0;
  int k;
  int st0 = 0;
  int st4 = 0;
  int fe = 0;
  int n_low = 0;
  logic hr = 1'b0;
  logic [1:0] fl = 2'h3;
  logic cyc_done;
  logic [3:0] full_ev;
  localparam int RR_CYC = 200;
  always #50 clk = ~clk;
  // starts on channel 0 and on the offset channel, and fullness pulses, sampled mid cycle
  always @(negedge clk)
  begin
    if (adc_start === 1'b1 && adc_chan == 3'h0)
      st0++;
    if (adc_start === 1'b1 && adc_chan == OFFSET_CH)
      st4++;
    if (full_ev !== 4'h0)
      fe++;
  end
  pas_adc_model i_adc (.clk(clk), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_done(adc_done), .adc_bus(adc_bus), .adc_sense(adc_sense));
  pas_sequencer #(.RR_PERIOD_CYC(RR_CYC), .SLOW_PERIOD_CYC(400)) i_dut (.clk(clk), .srst(srst),
    .chan_enable(en), .conv_mode(mode), .bus_bipolar(bb), .sense_bipolar(sb),
    .half_range_setting(hr), .acc_select(sel), .full_level(fl), .adaptive_en(1'b0),
    .slow_pin(1'b0), .cc_alert_en(1'b1), .refresh(rf[0]), .refresh_v(rf[1]),
    .refresh_g(rf[2]), .adc_done(adc_done), .adc_bus(adc_bus), .adc_sense(adc_sense),
    .adc_start(adc_start), .adc_chan(adc_chan), .bus_result(bus_r), .sense_result(sense_r),
    .bus_avg_result(bus_a), .sense_avg_result(sense_a), .power_result(pow_r),
    .acc_result(acc_r), .count_result(cnt_r), .full_event(full_ev), .alert_n(alert_n),
    .cycle_done(cyc_done), .asleep(asleep));
  // ****************************************
  // tasks
  // ****************************************
  task check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task pulse(input logic [2:0] r);
    @(negedge clk);
    rf = r;
    @(negedge clk);
    rf = 3'h0;
  endtask : pulse
  task count_low();
    n_low = 0;
    repeat (300)
    begin
      @(negedge clk);
      if (alert_n === 1'b0)
        n_low++;
    end
  endtask : count_low
  task check_ch(input int n);
    logic [16:0] b;
    logic [16:0] s;
    logic signed [29:0] p;
    logic [55:0] a;
    logic [16:0] v;
    for (int c = 0; c < 3; c++)
    begin
      b = 17'h0_8000 + 17'(c * 16);
      s = 17'(-64 * (c + 1));
      v = hr ? (s << 1) : s;
      p = $signed(s) * $signed(b[16:3]);
      a = (c == 0) ? {{26{p[29]}}, p} : (c == 1) ? {{39{s[16]}}, s} : {{39{b[16]}}, b};
      check(64'(cnt_r[c]), 64'(n));
      check(64'(acc_r[c]), 64'(56'(a * 56'(n))));
      check(64'(pow_r[c]), 64'($unsigned(p)));
      check(64'(bus_r[c]), 64'(bb ? b[16:1] : b[15:0]));
      check(64'(sense_r[c]), 64'(sb ? v[16:1] : v[15:0]));
      if (n > 8)
      begin
        check(64'(sense_a[c]), 64'(sb ? v[16:1] : v[15:0]));
        check(64'(bus_a[c]), 64'(bb ? b[16:1] : b[15:0]));
      end
    end
    check(64'(cnt_r[3]), 64'h0);
  endtask : check_ch
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    fork
      begin
        #8_000_000;
        mismatches++;
        give_verdict();
      end
    join_none
    repeat (12) @(negedge clk);
    srst = 1'b0;
    check(64'(asleep), 64'h1);
    check(64'(alert_n), 64'h1);
    check(64'(cnt_r[0]), 64'h0);
    en = 4'h7;
    pulse(3'h1);
    for (k = 0; k < 2000 && alert_n !== 1'b0; k++) @(negedge clk);
    for (k = 0; k < 200 && alert_n === 1'b0; k++) @(negedge clk);
    check(64'(k), 64'(ALERT_PULSE_CYC));
    check(64'(cnt_r[0]), 64'h0);
    repeat (20000) @(negedge clk);
    mode = MODE_SINGLE8;
    pulse(3'h1);
    check_ch(1);
    repeat (20000) @(negedge clk);
    bb = 1'b1;
    sb = 1'b1;
    pulse(3'h2);
    check_ch(9);
    repeat (20000) @(negedge clk);
    en = 4'h0;
    hr = 1'b1;
    pulse(3'h4);
    check_ch(17);
    repeat (300) @(negedge clk);
    check(64'(asleep), 64'h1);
    fl = 2'h0;
    mode = MODE_CONT;
    en = 4'h1;
    for (k = 0; k < 1000 && cyc_done !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    for (k = 1; k < 1000 && cyc_done !== 1'b1; k++) @(negedge clk);
    check(64'(k), 64'(RR_CYC));
    en = 4'h0;
    repeat (300) @(negedge clk);
    mode = MODE_BURST;
    en = 4'h1;
    k = st4;
    count_low();
    check(64'(n_low), 64'h0);
    check(64'(st4 - k), 64'h0);
    mode = MODE_FAST;
    count_low();
    check(64'(n_low != 0), 64'h1);
    check(64'(st4 > k), 64'h1);
    en = 4'h0;
    repeat (100) @(negedge clk);
    pulse(3'h1);
    check(64'(cnt_r[0]), 64'(st0));
    check(64'(fe), 64'h0);
    give_verdict();
  end
endmodule : test_power_accumulator_sequencer
